// ### fast_link_drop_pkg.sv
// Constants, field layout and carrier types for the fast link drop block.
// Assumes a single 25 MHz clock and an AHB-Lite master with word accesses.
// Function
// [RULE1] Polarity field inverts transmit and receive pairs
// [RULE2] Exchange zero: normal pair roles
// [RULE3] Exchange one: swap transmit and receive pairs
// [RULE4] Software sets both bits for port mirror
// [RULE5] Bit3: 32 receive errors per window drop
// [RULE6] Bit2: 20 code violations per window drop
// [RULE7] Bit1: 20 low-SNR crossings per window drop
// [RULE8] Bit0: energy loss drops link at once
// [RULE9] Drop is OR of enabled conditions
// [RULE10] Descrambler bit enables drop on lock loss
// [RULE11] Event counters clear at each window end
package fast_link_drop_pkg;

  localparam int unsigned CLOCK_HZ = 25_000_000;
  localparam int unsigned WINDOW_NS = 10_000;
  localparam int unsigned WINDOW_CYCLES = WINDOW_NS / (1_000_000_000 / CLOCK_HZ);

  localparam int unsigned RXERR_LIMIT = 32;
  localparam int unsigned CODEVIOL_LIMIT = 20;
  localparam int unsigned SNR_LIMIT = 20;

  // Byte addresses on the register bus
  localparam logic [11:0] LINK_CTRL3_ADDR = 12'h000;
  localparam logic [11:0] DROP_STATUS_ADDR = 12'h004;

  localparam int unsigned SEL_ENERGY_BIT = 0;
  localparam int unsigned SEL_SNR_BIT = 1;
  localparam int unsigned SEL_CODEVIOL_BIT = 2;
  localparam int unsigned SEL_RXERR_BIT = 3;
  localparam int unsigned EXCHANGE_BIT = 5;
  localparam int unsigned POLARITY_BIT = 6;
  localparam int unsigned DESCRAMBLER_BIT = 10;
  localparam logic [15:0] LINK_CTRL3_WMASK = 16'h0460;
  localparam logic [15:0] LINK_CTRL3_WMASK_SEL = 16'h000f;
  localparam logic [15:0] LINK_CTRL3_RESET = 16'h0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Raw event strobes from the receive path
  typedef struct packed {
    logic rxError;
    logic codeViolation;
    logic lowSnr;
    logic energyLoss;
    logic lockLoss;
  } rx_events_t;

  // Pair steering toward the analog front end
  typedef struct packed {
    logic exchangePairs;
    logic invertTransmit;
    logic invertReceive;
  } pair_ctrl_t;

endpackage

// ### window_event_counter.sv
// Counts event strobes within a repeating window and flags a threshold hit.
// Assumes the window end pulse and events are on the same clock.
`timescale 1ns/10ps
module window_event_counter
  import fast_link_drop_pkg::*;
#(
  parameter int unsigned LIMIT = 20,
  parameter int unsigned CW = $clog2(LIMIT + 1)
)(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic event_in,
  input wire logic windowEnd,
  output logic hit
);

  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;

  always_comb
  begin
    nxt_count = count_ff;
    if (windowEnd || !enable)
    begin
      nxt_count = '0; // RULE11
    end
    else if (event_in && count_ff != LIMIT_C)
    begin
      nxt_count = count_ff + ONE_C;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_ff <= '0;
    end
    else
    begin
      count_ff <= nxt_count;
    end
  end

  assign hit = enable && (count_ff == LIMIT_C);

endmodule // window_event_counter

// ### fast_link_drop.sv
// Fast link drop and pair role control with an AHB-Lite register slave.
// Assumes event inputs come from another domain and are synchronised here.
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module fast_link_drop
  import fast_link_drop_pkg::*;
#(
  parameter int unsigned WINDOW_LEN = WINDOW_CYCLES
)(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire rx_events_t rxEvents,
  input wire logic linkUp,
  output pair_ctrl_t pairCtrl,
  output logic linkDrop
);

  localparam int unsigned WW = $clog2(WINDOW_LEN + 1);
  localparam logic [WW-1:0] WIN_LAST = WW'(WINDOW_LEN - 1);
  localparam logic [WW-1:0] WIN_ONE = WW'(1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detect

  rx_events_t syncA_ff, syncB_ff, prev_ff;
  logic linkA_ff, linkB_ff;
  rx_events_t pulses;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      prev_ff <= '0;
      linkA_ff <= 1'b0;
      linkB_ff <= 1'b0;
    end
    else
    begin
      syncA_ff <= rxEvents;
      syncB_ff <= syncA_ff;
      prev_ff <= syncB_ff;
      linkA_ff <= linkUp;
      linkB_ff <= linkA_ff;
    end
  end

  // Events are counted on rising edges, so a long strobe counts once
  assign pulses = syncB_ff & ~prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  logic [15:0] ctrl_ff, nxt_ctrl;
  logic wrPend_ff, nxt_wrPend;
  logic [11:0] addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic dropSticky_ff, nxt_dropSticky;
  logic drop_ff, nxt_drop;
  pair_ctrl_t pair_ff, nxt_pair;
  logic addrPhase;
  logic dropNow;
  logic ctrlWrite;
  logic statusWrite;

  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign ctrlWrite = wrPend_ff && (addr_ff == LINK_CTRL3_ADDR);
  assign statusWrite = wrPend_ff && (addr_ff == DROP_STATUS_ADDR);

  always_comb
  begin
    nxt_wrPend = addrPhase && hwrite;
    nxt_addr = addrPhase ? haddr : addr_ff;
    nxt_ctrl = ctrl_ff;
    if (ctrlWrite)
    begin
      nxt_ctrl = hwdata[15:0] & (LINK_CTRL3_WMASK | LINK_CTRL3_WMASK_SEL);
    end
    // Set wins over a clear in the same cycle
    nxt_dropSticky = dropNow || (dropSticky_ff && !(statusWrite && hwdata[0]));
    nxt_rdata = '0;
    // Next values, so a read right behind a write sees the new word
    if (addrPhase && !hwrite)
    begin
      unique case (haddr)
        LINK_CTRL3_ADDR: nxt_rdata = {16'h0000, nxt_ctrl};
        DROP_STATUS_ADDR: nxt_rdata = {30'h0, drop_ff, nxt_dropSticky};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_ff <= LINK_CTRL3_RESET;
      wrPend_ff <= 1'b0;
      addr_ff <= '0;
      rdata_ff <= '0;
      dropSticky_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      wrPend_ff <= nxt_wrPend;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
      dropSticky_ff <= nxt_dropSticky;
    end
  end

  // Zero wait states and OKAY always
  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Window timer

  logic [WW-1:0] win_ff, nxt_win;
  logic windowEnd;

  assign windowEnd = (win_ff == WIN_LAST);

  always_comb
  begin
    nxt_win = windowEnd ? '0 : win_ff + WIN_ONE;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      win_ff <= '0;
    end
    else
    begin
      win_ff <= nxt_win;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold counters

  // One counter per threshold condition: low SNR, code violation, receive error
  localparam int unsigned CNT_LIMIT [3] = '{SNR_LIMIT, CODEVIOL_LIMIT, RXERR_LIMIT};
  localparam int unsigned CNT_SEL [3] = '{SEL_SNR_BIT, SEL_CODEVIOL_BIT, SEL_RXERR_BIT};

  logic [2:0] cntEvent;
  logic [2:0] cntHit;

  assign cntEvent = {pulses.rxError, pulses.codeViolation, pulses.lowSnr};

  for (genvar g = 0; g < 3; g++)
  begin : gCount
    window_event_counter #(.LIMIT(CNT_LIMIT[g])) counter (
      .clock(clock),
      .reset_n(reset_n),
      .enable(ctrl_ff[CNT_SEL[g]]), // RULE5 RULE6 RULE7
      .event_in(cntEvent[g]),
      .windowEnd(windowEnd),
      .hit(cntHit[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drop decision and pair steering

  always_comb
  begin
    dropNow = (|cntHit) // RULE9
      || (ctrl_ff[SEL_ENERGY_BIT] && syncB_ff.energyLoss) // RULE8
      || (ctrl_ff[DESCRAMBLER_BIT] && syncB_ff.lockLoss); // RULE10
    // Drop holds until the link goes down so it is never missed
    nxt_drop = dropNow || (drop_ff && linkB_ff);
    nxt_pair.exchangePairs = ctrl_ff[EXCHANGE_BIT]; // RULE2 RULE3
    nxt_pair.invertTransmit = ctrl_ff[POLARITY_BIT]; // RULE1
    nxt_pair.invertReceive = ctrl_ff[POLARITY_BIT]; // RULE1
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drop_ff <= 1'b0;
      pair_ff <= '0;
    end
    else
    begin
      drop_ff <= nxt_drop;
      pair_ff <= nxt_pair;
    end
  end

  assign linkDrop = drop_ff;
  assign pairCtrl = pair_ff;

endmodule // fast_link_drop

// ### fast_link_drop_asserts.sv
// Port checks for the fast link drop block.
// Assumes one clock domain and a bind onto the top module.
`timescale 1ns/10ps
module fast_link_drop_asserts
  import fast_link_drop_pkg::*;
#(
  parameter int unsigned WINDOW_LEN = WINDOW_CYCLES
)(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire rx_events_t rxEvents,
  input wire pair_ctrl_t pairCtrl,
  input wire logic linkDrop
);
  logic wrPend_ff, nxt_wrPend;
  logic [15:0] cfg_ff, nxt_cfg;
  logic [2:0] pairSel;
  assign pairSel = {cfg_ff[EXCHANGE_BIT], cfg_ff[POLARITY_BIT], cfg_ff[POLARITY_BIT]};
  // Shadow of the control word, built from bus writes only
  always_comb
  begin
    nxt_wrPend = hsel && hready && htrans == HTRANS_NONSEQ && hwrite
      && haddr == LINK_CTRL3_ADDR;
    nxt_cfg = wrPend_ff ? hwdata[15:0] & (LINK_CTRL3_WMASK | LINK_CTRL3_WMASK_SEL) : cfg_ff;
  end
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      wrPend_ff <= 1'b0;
      cfg_ff <= 16'h0000;
    end
    else
    begin
      wrPend_ff <= nxt_wrPend;
      cfg_ff <= nxt_cfg;
    end
  ////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence rd_s;
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  endsequence
  ready_const_a: assert property (hreadyout) else $error("hreadyout low");
  okay_resp_a: assert property (!hresp) else $error("hresp not OKAY");
  pair_map_a: assert property ($stable(pairSel)[*2] |-> pairCtrl == pairSel)
    else $error("pair steering differs from control word");
  energy_drop_a: assert property
    ((rxEvents.energyLoss && cfg_ff[SEL_ENERGY_BIT])[*5] |-> linkDrop)
    else $error("energy loss did not drop link");
  lock_drop_a: assert property
    ((rxEvents.lockLoss && cfg_ff[DESCRAMBLER_BIT])[*5] |-> linkDrop)
    else $error("lock loss did not drop link");
  quiet_cfg_a: assert property ((cfg_ff == 16'h0000)[*8] |-> !$rose(linkDrop))
    else $error("drop with nothing enabled");
  rd_mask_a: assert property (rd_s ##0 haddr == LINK_CTRL3_ADDR |=> hrdata == {16'h0, cfg_ff})
    else $error("control word read back wrong");
  unmapped_rd_a: assert property (rd_s ##0 haddr > DROP_STATUS_ADDR |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // fast_link_drop_asserts

bind fast_link_drop fast_link_drop_asserts #(.WINDOW_LEN(WINDOW_LEN)) chk (.clock, .reset_n,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .rxEvents, .pairCtrl, .linkDrop);

// ### link_partner.sv
// Far-end model: receive event strobes and link state.
// Assumes the bench calls its tasks right after a rising edge.
`timescale 1ns/10ps
module link_partner
  import fast_link_drop_pkg::*;
(
  input wire logic clock,
  output rx_events_t rxEvents,
  output logic linkUp
);
  initial
  begin
    rxEvents = '0;
    linkUp = 1'b1;
  end
  // Quiet cycle between strobes so every event is a fresh rising edge
  task automatic pulses(input int b, input int n);
    repeat (n)
    begin
      rxEvents[b] <= 1'b1;
      @(posedge clock);
      rxEvents[b] <= 1'b0;
      @(posedge clock);
    end
  endtask
  task automatic level(input int b, input logic v);
    rxEvents[b] <= v;
    @(posedge clock);
  endtask
  task automatic setLink(input logic v);
    linkUp <= v;
    @(posedge clock);
  endtask
endmodule // link_partner

// ### fast_link_drop_tb.sv
// Bench: AHB-Lite register accesses and drop scenarios.
// Assumes the far-end model drives the event lines.
`timescale 1ns/10ps
module fast_link_drop_tb import fast_link_drop_pkg::*;;
  localparam int W = 200;
  logic clock = 0, reset_n = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata;
  logic hreadyout, hresp, linkUp, linkDrop;
  rx_events_t rxEvents;
  pair_ctrl_t pairCtrl;
  int errors = 0, tests_run = 0, cyc = 0;
  logic [31:0] wv[4] = '{32'hffffffff, 32'h40, 32'h20, 32'h0};
  int evb[5] = '{4, 3, 2, 1, 0};
  int lim[5] = '{RXERR_LIMIT, CODEVIOL_LIMIT, SNR_LIMIT, 0, 0};
  int sel[5] = '{SEL_RXERR_BIT, SEL_CODEVIOL_BIT, SEL_SNR_BIT, SEL_ENERGY_BIT, DESCRAMBLER_BIT};
  fast_link_drop #(.WINDOW_LEN(W)) uut (.clock, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxEvents,
    .linkUp, .pairCtrl, .linkDrop);
  link_partner lp (.clock, .rxEvents, .linkUp);
  initial forever #20 clock = ~clock;
  always @(posedge clock) if (reset_n) cyc <= cyc + 1;
  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    int n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1)
    begin
      if (++n > 20)
      begin
        errors++;
        test_done();
      end
      @(posedge clock);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, exp);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    step();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    step();
    if (!wr) check("hrdata", hrdata, exp);
  endtask
  // Start bursts early in a window so a full burst fits inside it
  task automatic align();
    int n = 0;
    while (cyc % W != 10)
    begin
      if (++n > W)
      begin
        errors++;
        test_done();
      end
      @(posedge clock);
    end
  endtask
  task automatic settle(input logic exp);
    int n = 0;
    while (n < 10 && !(exp && linkDrop === 1'b1))
    begin
      n++;
      @(posedge clock);
    end
    check("linkDrop", 32'(linkDrop), 32'(exp));
  endtask
  task automatic fire(input int i, input int n, input logic exp);
    align();
    if (lim[i] > 0) lp.pulses(evb[i], n);
    else lp.level(evb[i], 1'b1);
    settle(exp);
    lp.level(evb[i], 1'b0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    bus(0, LINK_CTRL3_ADDR, 0, {16'h0, LINK_CTRL3_RESET});
    foreach (wv[k])
    begin
      bus(1, LINK_CTRL3_ADDR, wv[k], 0);
      bus(0, LINK_CTRL3_ADDR, 0, wv[k] & {16'h0, LINK_CTRL3_WMASK | LINK_CTRL3_WMASK_SEL});
      check("pairCtrl", 32'(pairCtrl), 32'({wv[k][5], wv[k][6], wv[k][6]}));
    end
    bus(1, 12'h008, 32'hffffffff, 0);
    bus(0, 12'h008, 0, 0);
    bus(0, LINK_CTRL3_ADDR, 0, 0);
    for (int i = 0; i < 5; i++)
    begin
      bus(1, LINK_CTRL3_ADDR, 0, 0);
      fire(i, lim[i], 0);
      bus(1, LINK_CTRL3_ADDR, 32'h1 << sel[i], 0);
      if (lim[i] > 0) fire(i, lim[i] - 1, 0);
      if (lim[i] > 0) fire(i, lim[i] - 1, 0);
      fire(i, lim[i], 1);
      bus(0, DROP_STATUS_ADDR, 0, 32'h3);
      lp.setLink(1'b0);
      align();
      settle(0);
      lp.setLink(1'b1);
      bus(1, DROP_STATUS_ADDR, 32'h1, 0);
      bus(0, DROP_STATUS_ADDR, 0, 0);
    end
    bus(1, LINK_CTRL3_ADDR, 32'h40f, 0);
    fire(3, 0, 1);
    test_done();
  end
endmodule // fast_link_drop_tb
